/* File: verilog/cpuam_pkg.sv */
// Package for the address-mode and reset-source block of the core
package cpuam_pkg;
  localparam int ADDR_W = 13;
  // Addressing mode encodings
  typedef enum logic [3:0] {
    CPUAM_IMM = 4'h0,
    CPUAM_DIR = 4'h1,
    CPUAM_EXT = 4'h2,
    CPUAM_REL = 4'h3,
    CPUAM_IX = 4'h4,
    CPUAM_IX1 = 4'h5,
    CPUAM_IX2 = 4'h6,
    CPUAM_BSC = 4'h7,
    CPUAM_BTB = 4'h8,
    CPUAM_INH = 4'h9
  } cpuam_mode_t;
  // Reset sequencer states
  typedef enum logic [1:0] {
    CPUAM_RS_POR = 2'b00,
    CPUAM_RS_PIN = 2'b01,
    CPUAM_RS_RUN = 2'b10
  } cpuam_rst_t;
  localparam logic [12:0] RAM_LO = 13'h0090;
  localparam logic [12:0] RAM_HI = 13'h01FF;
  localparam logic [12:0] ROM_LO = 13'h0F00;
  localparam logic [12:0] ROM_HI = 13'h1FFF;
  localparam logic [12:0] VEC_RESET_HI = 13'h1FFE;
  localparam logic [12:0] VEC_RESET_LO = 13'h1FFF;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam int CLK_HZ = 10_000_000;
  localparam int POR_CYCLES = 4064;
  // Pin low of one and a half cycles rounds up to two clock samples
  localparam int PIN_LOW_TCYC_X2 = 3;
  localparam int PIN_LOW_CYCLES = (PIN_LOW_TCYC_X2 + 1) / 2;
  localparam logic [1:0] PIN_LOW_CNT = 2'(PIN_LOW_CYCLES);
endpackage

/* File: verilog/cpuam_core.sv */
// Effective-address generation and reset-source combiner
`timescale 1ns/1ps
module cpuam_core #(
  parameter bit WATCHDOG_EN = 1'b1,
  parameter int POR_DELAY = cpuam_pkg::POR_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reset_n,
  input wire logic i_watchdog_timeout,
  input wire logic i_fetch_valid,
  input wire logic [12:0] i_fetch_addr,
  input wire logic i_decode,
  input wire cpuam_pkg::cpuam_mode_t i_mode,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_byte2,
  input wire logic [7:0] i_byte3,
  input wire logic [7:0] i_index,
  input wire logic [12:0] i_pc,
  input wire logic i_cond_true,
  input wire logic [7:0] i_mem_data,
  input wire logic i_mode_in,
  output logic [12:0] o_effective_address,
  output logic [7:0] o_operand,
  output logic o_operand_valid,
  output logic [1:0] o_inst_len,
  output logic [12:0] o_next_pc,
  output logic [2:0] o_bit_num,
  output logic o_carry_wr,
  output logic o_carry,
  output logic o_branch_taken,
  output logic o_int_reset,
  output logic o_illegal_fetch_flag,
  output logic o_load_vector,
  output logic [12:0] o_vector_hi_addr,
  output logic [12:0] o_vector_lo_addr,
  output logic o_set_imask,
  output logic [7:0] o_sp_init,
  output logic o_mode_out
);
  import cpuam_pkg::*;

  // Combinational results before registering
  // Everything here settles within one cycle of the decode strobe
  logic [12:0] next_ea;
  logic [7:0] next_operand;
  logic next_operand_valid;
  logic [1:0] next_len;
  logic [12:0] next_pc_seq;
  logic [12:0] next_target;
  logic next_taken;
  logic next_carry_wr;
  logic next_carry;
  logic tested_bit;
  logic [12:0] rel_offset;
  // Reset sequencing state
  // Sequencer leaves power-on only once per i_rst assertion
  cpuam_rst_t rst_state;
  logic [12:0] por_cnt;
  logic [1:0] pin_low_cnt;
  logic pin_reset;
  logic illegal_fetch;
  logic wd_reset;
  logic any_source;
  logic int_reset_q;
  logic held_mode;

  // Sign-extended branch offset, taken from the last instruction byte
  // Relative and bit-branch modes keep the offset in different bytes
  always_comb begin
    if (i_mode == CPUAM_BTB) begin
      rel_offset = {{5{i_byte3[7]}}, i_byte3};
    end else begin
      rel_offset = {{5{i_byte2[7]}}, i_byte2};
    end
  end

  // Bit under test from the fetched memory byte
  assign tested_bit = i_mem_data[i_opcode[3:1]];

  // Address and length decode per mode
  // Unused mode codes fall to a one-byte length with no address
  always_comb begin
    next_ea = 13'h0000;
    next_operand = 8'h00;
    next_operand_valid = 1'b0;
    next_len = 2'd1;
    next_taken = 1'b0;
    next_carry_wr = 1'b0;
    next_carry = 1'b0;
    case (i_mode)
      CPUAM_IMM: begin
        // Operand needs no memory access
        next_operand = i_byte2;
        next_operand_valid = 1'b1;
        next_len = 2'd2;
      end
      CPUAM_DIR: begin
        next_ea = {5'h00, i_byte2};
        next_len = 2'd2;
      end
      CPUAM_EXT: begin
        // Upper bits beyond 13 are dropped
        next_ea = {i_byte2[4:0], i_byte3};
        next_len = 2'd3;
      end
      CPUAM_REL: begin
        next_len = 2'd2;
        next_taken = i_cond_true;
      end
      CPUAM_IX: begin
        next_ea = {5'h00, i_index};
      end
      CPUAM_IX1: begin
        // Nine-bit sum keeps the carry, so 0x1FE is the top
        next_ea = {4'h0, {1'b0, i_index} + {1'b0, i_byte2}};
        next_len = 2'd2;
      end
      CPUAM_IX2: begin
        next_ea = 13'({i_byte2[4:0], i_byte3} + {5'h00, i_index});
        next_len = 2'd3;
      end
      CPUAM_BSC: begin
        next_ea = {5'h00, i_byte2};
        next_len = 2'd2;
      end
      CPUAM_BTB: begin
        next_ea = {5'h00, i_byte2};
        next_len = 2'd3;
        // Opcode bit 0 low means branch when set
        next_taken = (tested_bit == ~i_opcode[0]);
        next_carry_wr = 1'b1;
        next_carry = tested_bit;
      end
      CPUAM_INH: begin
        next_len = 2'd1;
      end
      default: begin
        next_len = 2'd1;
      end
    endcase
  end

  // Sequential and branch target, wrapping in the 8K map
  assign next_pc_seq = 13'(i_pc + {11'h000, next_len});
  assign next_target = next_taken ?
    13'(next_pc_seq + rel_offset) : next_pc_seq;

  // Registered decode outputs
  // Values hold until the next decode strobe, except o_carry_wr, which clears after one cycle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_effective_address <= 13'h0000;
      o_operand <= 8'h00;
      o_operand_valid <= 1'b0;
      o_inst_len <= 2'd1;
      o_next_pc <= 13'h0000;
      o_bit_num <= 3'h0;
      o_carry_wr <= 1'b0;
      o_carry <= 1'b0;
      o_branch_taken <= 1'b0;
    end else if (i_decode) begin
      o_effective_address <= next_ea;
      o_operand <= next_operand;
      o_operand_valid <= next_operand_valid;
      o_inst_len <= next_len;
      o_next_pc <= next_target;
      o_bit_num <= i_opcode[3:1];
      o_carry_wr <= next_carry_wr;
      o_carry <= next_carry;
      o_branch_taken <= next_taken;
    end else begin
      // Carry strobe is one cycle wide
      o_carry_wr <= 1'b0;
    end
  end

  // Pin low filter: needs consecutive low samples
  // A one-cycle glitch on the pin is ignored; two lows are needed
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_low_cnt <= 2'd0;
    end else if (i_reset_n) begin
      pin_low_cnt <= 2'd0;
    end else if (pin_low_cnt != PIN_LOW_CNT) begin
      pin_low_cnt <= pin_low_cnt + 2'd1;
    end
  end
  assign pin_reset = (pin_low_cnt == PIN_LOW_CNT);

  // Illegal fetch detection outside RAM and ROM
  // Fetches are not judged while in reset, so a stale address
  // left on the fetch bus cannot keep the core in reset
  assign illegal_fetch = i_fetch_valid && !int_reset_q &&
    !((i_fetch_addr >= RAM_LO && i_fetch_addr <= RAM_HI) ||
      (i_fetch_addr >= ROM_LO && i_fetch_addr <= ROM_HI));

  // Illegal-fetch flag shown for one cycle as a reset cause
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_illegal_fetch_flag <= 1'b0;
    end else begin
      o_illegal_fetch_flag <= illegal_fetch;
    end
  end

  // Watchdog reset exists only when built in
  // When tied off, a timeout has no effect at all
  assign wd_reset = WATCHDOG_EN && i_watchdog_timeout;
  assign any_source = pin_reset || wd_reset ||
    o_illegal_fetch_flag;

  // Power-on delay then pin hold sequencer
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rst_state <= CPUAM_RS_POR;
      por_cnt <= 13'h0000;
    end else begin
      case (rst_state)
        CPUAM_RS_POR: begin
          // Count from oscillator start (release of i_rst)
          if (por_cnt == 13'(POR_DELAY - 1)) begin
            rst_state <= i_reset_n ? CPUAM_RS_RUN : CPUAM_RS_PIN;
          end else begin
            por_cnt <= por_cnt + 13'h0001;
          end
        end
        CPUAM_RS_PIN: begin
          if (i_reset_n) begin
            rst_state <= CPUAM_RS_RUN;
          end
        end
        CPUAM_RS_RUN: begin
          rst_state <= CPUAM_RS_RUN;
        end
        default: begin
          rst_state <= CPUAM_RS_POR;
        end
      endcase
    end
  end

  // Combined internal reset, released on a clock edge
  // One cycle of latency keeps the release free of glitches
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      int_reset_q <= 1'b1;
    end else begin
      int_reset_q <= (rst_state != CPUAM_RS_RUN) || any_source;
    end
  end
  // Internal only; the pin is never driven back
  assign o_int_reset = int_reset_q;

  // Operating mode held through a watchdog reset
  // Only i_rst clears it; internal resets leave it alone
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      held_mode <= 1'b0;
    end else if (!int_reset_q) begin
      held_mode <= i_mode_in;
    end
  end
  assign o_mode_out = held_mode;

  // Vector load pulse on the cycle reset releases
  // Pulse rises on the same edge that drops the internal reset
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_load_vector <= 1'b0;
    end else begin
      o_load_vector <= int_reset_q &&
        !((rst_state != CPUAM_RS_RUN) || any_source);
    end
  end
  assign o_set_imask = o_load_vector;
  // Fixed reset values presented to the fetch and stack logic
  assign o_vector_hi_addr = VEC_RESET_HI;
  assign o_vector_lo_addr = VEC_RESET_LO;
  assign o_sp_init = SP_RESET;
endmodule

/* File: verif/cpuam_core_assertions.sv */
// Assertion checker for the address-mode and reset block
`timescale 1ns/1ps
module cpuam_chk
  import cpuam_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reset_n,
  input wire logic i_watchdog_timeout,
  input wire logic i_fetch_valid,
  input wire logic [12:0] i_fetch_addr,
  input wire logic i_decode,
  input wire cpuam_pkg::cpuam_mode_t i_mode,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_byte2,
  input wire logic [7:0] i_byte3,
  input wire logic [7:0] i_index,
  input wire logic [7:0] i_mem_data,
  input wire logic [12:0] o_effective_address,
  input wire logic [1:0] o_inst_len,
  input wire logic o_carry_wr,
  input wire logic o_carry,
  input wire logic o_int_reset,
  input wire logic o_illegal_fetch_flag,
  input wire logic o_load_vector,
  input wire logic o_set_imask,
  input wire logic o_mode_out
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  logic tbit; // Bit selected by the opcode from the tested byte
  assign tbit = i_mem_data[i_opcode[3:1]];
  // Fetch outside both memories, then flag and reset in turn
  sequence s_bad_fetch;
    i_fetch_valid && !o_int_reset && !((i_fetch_addr >= RAM_LO &&
      i_fetch_addr <= RAM_HI) || i_fetch_addr >= ROM_LO);
  endsequence
  sequence s_fetch_rst;
    o_illegal_fetch_flag ##1 o_int_reset;
  endsequence
  sequence s_vec_pulse;
    (o_load_vector && o_set_imask) ##1 !o_load_vector;
  endsequence
  AST_ILL_FETCH: assert property (
    s_bad_fetch |=> s_fetch_rst) else $error("bad fetch not reset");
  AST_DIR_EA: assert property (
    i_decode && i_mode == CPUAM_DIR |=> o_inst_len == 2'h2 &&
    o_effective_address == {5'h00, $past(i_byte2)})
    else $error("direct address wrong");
  AST_EXT_EA: assert property (
    i_decode && i_mode == CPUAM_EXT |=> o_effective_address ==
    {$past(i_byte2[4:0]), $past(i_byte3)}) else $error("extended wrong");
  AST_IX1_EA: assert property (
    i_decode && i_mode == CPUAM_IX1 |=> o_effective_address ==
    {5'h00, $past(i_index)} + {5'h00, $past(i_byte2)})
    else $error("index offset sum wrong");
  AST_BTB_CARRY: assert property (
    i_decode && i_mode == CPUAM_BTB |=> o_carry_wr &&
    o_carry == $past(tbit)) else $error("tested bit not in carry");
  AST_PIN_RST: assert property (
    !i_reset_n [*2] |-> ##2 o_int_reset) else $error("pin low ignored");
  AST_WDOG_RST: assert property (
    $rose(i_watchdog_timeout) |-> ##[1:2] o_int_reset)
    else $error("watchdog reset missing");
  AST_MODE_HOLD: assert property (
    o_int_reset ##1 o_int_reset |-> $stable(o_mode_out))
    else $error("mode changed in reset");
  AST_VEC_LOAD: assert property (
    $fell(o_int_reset) |-> s_vec_pulse) else $error("no vector load");
endmodule
bind cpuam_core cpuam_chk u_chk (.*);

/* File: verif/cpuam_mem_model.sv */
// Behavioural stand-in for the on-chip ROM and RAM
`timescale 1ns/1ps
module cpuam_mem_model (
  input wire logic [12:0] i_addr,
  output logic [7:0] o_data
);
  // Address-derived pattern, so neighbouring bytes differ
  assign o_data = i_addr[7:0] ^ 8'hA5;
endmodule

/* File: verif/cpuam_core_tb_top.sv */
// Self-checking bench for the address-mode and reset block
`timescale 1ns/1ps
module cpuam_core_tb_top;
  import cpuam_pkg::*;
  localparam int POR_D = 8; // Short power-on count keeps the run brief
  typedef struct packed {
    cpuam_mode_t m;
    logic [12:0] v;
    logic [12:0] n;
    logic [1:0] l;
    logic c;
    logic t;
    logic [2:0] b;
  } cpuam_exp_t;
  logic i_clk_sys = 0, i_rst = 1, i_reset_n = 1, i_watchdog_timeout = 0;
  logic i_fetch_valid = 0, i_decode = 0, i_cond_true = 0, i_mode_in = 0;
  logic [12:0] i_fetch_addr = '0, i_pc = '0;
  cpuam_mode_t i_mode = CPUAM_IMM;
  logic [7:0] i_opcode = '0, i_byte2 = '0, i_byte3 = '0, i_index = '0;
  logic [7:0] i_mem_data, o_operand, o_sp_init;
  logic [12:0] o_effective_address, o_next_pc, o_vector_hi_addr;
  logic [12:0] o_vector_lo_addr;
  logic [1:0] o_inst_len;
  logic [2:0] o_bit_num;
  logic o_operand_valid, o_carry_wr, o_carry, o_branch_taken, o_int_reset;
  logic o_illegal_fetch_flag, o_load_vector, o_set_imask, o_mode_out;
  logic [12:0] fa [7] = '{13'h008F, 13'h0090, 13'h01FF, 13'h0200,
    13'h0EFF, 13'h0F00, 13'h1FFF}; // Fetch addresses at the map edges
  cpuam_exp_t exp_q[$]; // Expected decode results, oldest first
  int err_count = 0, n_checks = 0, cyc = 0, seed = 32'h0BEE;
  logic dec_q = 0; // A decode was taken at the last rising edge
  cpuam_core #(.POR_DELAY(POR_D)) dut (.*);
  cpuam_mem_model mem (.i_addr({5'h00, i_byte2}), .o_data(i_mem_data));
  initial begin
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for internal reset to drop
  task automatic wait_rel(output int k);
    k = 0;
    while (o_int_reset !== 1'b0 && k < 100) begin
      @(negedge i_clk_sys);
      k++;
    end
    check(o_int_reset, 1'b0);
    if (k > 0) check({o_load_vector, o_set_imask}, 2'h3);
  endtask
  // Drive one decode and note the result it should give
  task automatic dec(input cpuam_mode_t m, input logic [7:0] op, b2, b3, x,
    input logic [12:0] pc, input logic c);
    cpuam_exp_t e;
    logic [7:0] d;
    d = b2 ^ 8'hA5;
    e = '{m, {5'h00, b2}, 13'h0000, 2'h2, d[op[3:1]], 1'b0, op[3:1]};
    case (m)
      CPUAM_EXT: e.v = {b2[4:0], b3};
      CPUAM_IX2: e.v = {b2[4:0], b3} + {5'h00, x};
      CPUAM_IX: e.v = {5'h00, x};
      CPUAM_IX1: e.v = {5'h00, b2} + {5'h00, x};
      default: ;
    endcase
    if (m inside {CPUAM_EXT, CPUAM_IX2, CPUAM_BTB}) e.l = 2'h3;
    if (m inside {CPUAM_IX, CPUAM_INH}) e.l = 2'h1;
    e.n = pc + {11'h000, e.l};
    e.t = (m == CPUAM_REL && c) || (m == CPUAM_BTB && d[op[3:1]] != op[0]);
    if (m == CPUAM_REL && e.t) e.n = e.n + {{5{b2[7]}}, b2};
    if (m == CPUAM_BTB && e.t) e.n = e.n + {{5{b3[7]}}, b3};
    {i_mode, i_opcode, i_byte2, i_byte3} = {m, op, b2, b3};
    {i_index, i_pc, i_cond_true, i_decode} = {x, pc, c, 1'b1};
    exp_q.push_back(e);
    @(negedge i_clk_sys);
  endtask
  // Watcher: results land one edge after each decode
  always @(posedge i_clk_sys) dec_q <= i_decode;
  always @(negedge i_clk_sys) begin
    cpuam_exp_t e;
    if (dec_q && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(o_inst_len, e.l);
      check(o_next_pc, e.n);
      check(o_branch_taken, e.t);
      check(o_bit_num, e.b);
      check(o_operand_valid, e.m == CPUAM_IMM);
      if (e.m == CPUAM_IMM) check(o_operand, e.v[7:0]);
      else if (!(e.m inside {CPUAM_REL, CPUAM_INH}))
        check(o_effective_address, e.v);
      if (e.m == CPUAM_BTB)
        check({o_carry_wr, o_carry}, {1'b1, e.c});
      else
        check(o_carry_wr, 1'b0);
    end
  end
  // Hang guard
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    int k;
    logic [31:0] r, r2;
    logic bad;
    repeat (20) @(negedge i_clk_sys);
    i_rst = 1'b0;
    wait_rel(k);
    check(k inside {POR_D, POR_D + 1}, 1'b1);
    check(o_vector_hi_addr, 13'h1FFE);
    check(o_vector_lo_addr, 13'h1FFF);
    check(o_sp_init, 8'hFF);
    dec(CPUAM_IX1, 8'h00, 8'hFF, 8'h00, 8'hFF, 13'h0000, 1'b0);
    repeat (300) begin
      r = $random(seed);
      r2 = $random(seed);
      dec(cpuam_mode_t'(4'(r2[30:21] % 10)), r[7:0], r[15:8], r[23:16],
        r2[7:0], r2[20:8], r2[31]);
    end
    i_decode = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    // Each fetch address in turn; only unmapped ones reset
    foreach (fa[i]) begin
      {i_fetch_addr, i_fetch_valid} = {fa[i], 1'b1};
      @(negedge i_clk_sys);
      i_fetch_valid = 1'b0;
      bad = !((fa[i] >= 13'h0090 && fa[i] <= 13'h01FF) || fa[i] >= 13'h0F00);
      check(o_illegal_fetch_flag, bad);
      @(negedge i_clk_sys);
      check(o_int_reset, bad);
      wait_rel(k);
    end
    i_reset_n = 1'b0;
    repeat (3) @(negedge i_clk_sys);
    check(o_int_reset, 1'b1);
    i_reset_n = 1'b1;
    wait_rel(k);
    i_mode_in = 1'b1;
    i_watchdog_timeout = 1'b1;
    @(negedge i_clk_sys);
    check(o_int_reset, 1'b1);
    i_watchdog_timeout = 1'b0;
    i_mode_in = 1'b0;
    @(negedge i_clk_sys);
    check(o_mode_out, 1'b1);
    wait_rel(k);
    {i_rst, i_reset_n} = 2'h2;
    @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (POR_D + 4) @(negedge i_clk_sys);
    check(o_int_reset, 1'b1);
    i_reset_n = 1'b1;
    wait_rel(k);
    print_verdict;
  end
endmodule
